//--- src/smp_defs.svh
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH

// Clock rate of ref_clk in MHz.
`define SMP_CLK_MHZ        20
// Fuse read time in microseconds and its cycle count.
`define SMP_FUSE_US        50
`define SMP_FUSE_CYC       (`SMP_FUSE_US * `SMP_CLK_MHZ)
// Active time of one polling check in microseconds and its cycle count.
`define SMP_POLL_ACT_US    10
`define SMP_POLL_ACT_CYC   (`SMP_POLL_ACT_US * `SMP_CLK_MHZ)
// Serial word length and the code of the low-power entry command.
`define SMP_WORD_BITS      16
`define SMP_SLEEP_CMD      16'hA5C3
// Width of the synchroniser bundle and bit positions inside it.
`define SMP_SYNC_W         31
`define SMP_B_CSN          0
`define SMP_B_SCK          1
`define SMP_B_MOSI         2
`define SMP_B_INT          3
`define SMP_B_WAKE         4
`define SMP_B_UV           5
`define SMP_B_OV           6
`define SMP_B_IOOK         7
`define SMP_B_COMP         8
`define SMP_B_SW_LO        9
`define SMP_B_SW_HI        30
// Idle levels of the bundle: chip select, interrupt and wake lines idle high, and the
// battery is taken as in lockout, so a reset never slips into the fuse read before the
// synchroniser has seen the real supply level.
`define SMP_SYNC_RST       31'h0000_0039
// Number of switch channels.
`define SMP_CHANNELS       22

`endif

//--- src/smp_pin_sync.sv
`timescale 1ns/10ps
`include "smp_defs.svh"

module smp_pin_sync (
  input  wire logic ref_clk, // System clock.
  input  wire logic rst,     // Synchronous reset, active high.
  smp_sync_if.sync  pins     // Raw pins in, filtered levels out.
);
  import smp_pkg::*;

  smp_sync_st_t q;
  smp_sync_st_t d;

  // Three stages; the first is read only by the second, and a level is taken once
  // the second and third stages agree, which also filters one-cycle glitches.
  always_comb begin
    d    = q;
    d.s1 = pins.raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < `SMP_SYNC_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.clean[i] = q.s3[i];
      end
    end
  end

  // Registers reset to the idle levels of the lines.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= {`SMP_SYNC_RST, `SMP_SYNC_RST, `SMP_SYNC_RST, `SMP_SYNC_RST};
    end else begin
      q <= d;
    end
  end

  assign pins.clean = q.clean;

  // A filtered bit moves only where both later stages agreed, and then takes their value.
  chk_sync_agree: assert property (@(posedge ref_clk) disable iff (rst)
    (((q.clean ^ $past(q.clean)) & ($past(q.s2) ^ $past(q.s3))) == '0) &&
    (((q.clean ^ $past(q.s3)) & ~($past(q.s2) ^ $past(q.s3))) == '0))
    else $error("filtered level changed without agreeing stages");

endmodule : smp_pin_sync

//--- src/smp_pkg.sv
`include "smp_defs.svh"

package smp_pkg;

  // Operating states of the sequencer.
  typedef enum logic [2:0] {
    SMP_RESET  = 3'h0,
    SMP_UV     = 3'h1,
    SMP_FUSE   = 3'h2,
    SMP_NORMAL = 3'h3,
    SMP_SLEEP  = 3'h4,
    SMP_POLL   = 3'h5
  } smp_state_t;

  // State of the pin synchroniser.
  typedef struct packed {
    logic [`SMP_SYNC_W-1:0] s1;
    logic [`SMP_SYNC_W-1:0] s2;
    logic [`SMP_SYNC_W-1:0] s3;
    logic [`SMP_SYNC_W-1:0] clean;
  } smp_sync_st_t;

  // State of the sequencer core.
  typedef struct packed {
    smp_state_t                 state;
    logic [15:0]                cnt;
    logic [23:0]                pollTmr;
    logic [23:0]                intTmr;
    logic [`SMP_CHANNELS-1:0]   swRef;
    logic [`SMP_WORD_BITS-1:0]  rxSh;
    logic [`SMP_WORD_BITS-1:0]  txSh;
    logic [4:0]                 bitCnt;
    logic                       frameOk;
    logic                       uvSeen;
    logic                       porSeen;
    logic                       intPend;
    logic                       misoQ;
    logic                       csPrev;
    logic                       sckPrev;
    logic                       intPrev;
    logic                       wakePrev;
  } smp_core_st_t;

endpackage : smp_pkg

//--- src/smp_power_fsm.sv
`timescale 1ns/10ps
`include "smp_defs.svh"
// Behaviour
// - Serial output stays released while the battery supply is in lockout.
// - Chip select is ignored in lockout; a word cut by lockout is discarded.
// - A sticky flag reports that lockout occurred, readable after it ends.
// - Reset forces every setting to default and disables serial traffic.
// - A sticky flag reports that a power-on reset occurred.
// - Overvoltage limits current sources and keeps all settings.
// - Interrupt line is held low from power-on until ready to communicate.
// - Serial traffic is undefined until activation ends; host must wait.
// - Without the I/O supply state is kept but no serial traffic occurs.
// - Below reset threshold nothing runs.
// - In lockout: settings kept, serial refused, mux and sources off, oscillators on.
// - Leaving lockout reads fuses for about 50 us, then enters Normal mode.
// - Every command is taken in Normal mode; host sets low-power options there.
// - Wake line is driven low throughout Normal mode.
// - Fault detection runs in Normal mode.
// - Low-power mode is entered only by the dedicated serial command.
// - Low-power mode stops the fast oscillator and all fault detection.
// - Low-power mode wakes on timer, interrupt, select, wake line or comparator change.
// - Low-power mode polls switches periodically and compares with stored states.
// - Low battery during polling pauses it without waking.
// - After each poll, a detected change wakes; otherwise back to low power.
// - With all channel wake enables cleared, no switch change wakes and polling timer stops.

module smp_power_fsm (
  input  wire logic                      ref_clk,       // 20 MHz system clock.
  input  wire logic                      rst,           // Power-on reset, sync, active high.
  input  wire logic                      batteryUvRaw,  // Battery supply in lockout range.
  input  wire logic                      overVoltRaw,   // Battery supply overvoltage.
  input  wire logic                      ioSupplyOk,    // I/O supply present.
  input  wire logic                      compChangeRaw, // Comparator-only input changed.
  input  wire logic [`SMP_CHANNELS-1:0]  switchIn,      // Switch comparator levels.
  input  wire logic [`SMP_CHANNELS-1:0]  wakeEnMask,    // Wake enable per channel.
  input  wire logic                      wakePinWakeEn, // Wake line falling edge wakes.
  input  wire logic [23:0]               pollPeriod,    // Polling period in cycles.
  input  wire logic [23:0]               intTimerPeriod, // Wake timer in cycles, 0 is off.
  input  wire logic                      csN,           // Serial chip select, active low.
  input  wire logic                      sck,           // Serial clock from the host.
  input  wire logic                      mosi,          // Serial data in.
  output logic                           misoOut,       // Serial data out.
  output logic                           misoOeN,       // Serial data enable, low drives.
  input  wire logic                      intIn,         // Interrupt line level.
  output logic                           intOut,        // Interrupt line drive value.
  output logic                           intOeN,        // Interrupt enable, low pulls low.
  input  wire logic                      wakeIn,        // Wake line level.
  output logic                           wakeOut,       // Wake line drive value.
  output logic                           wakeOeN,       // Wake enable, low pulls low.
  output logic                           fastOscEn,     // Fast oscillator enable.
  output logic                           faultDetectEn, // Fault detectors enable.
  output logic                           currentSrcEn,  // Current sources enable.
  output logic                           currentLimit,  // Current sources limited.
  output logic                           muxEn,         // Analog output mux enable.
  output logic                           uvSeenFlag,    // Lockout has occurred.
  output logic                           porSeenFlag,   // Power-on reset has occurred.
  output smp_pkg::smp_state_t            stateOut       // Present operating state.
);
  import smp_pkg::*;

  localparam int FuseLast = `SMP_FUSE_CYC - 1;

  smp_core_st_t q;
  smp_core_st_t d;
  logic         uv;
  logic         ov;
  logic         ioOk;
  logic         csLvl;
  logic         sckLvl;
  logic         mosiLvl;
  logic         csFall;
  logic         csRise;
  logic         sckRise;
  logic         sckFall;
  logic         swChange;
  logic         wakeReq;

  smp_sync_if pins ();

  // The host clock is slow enough (eight ref_clk cycles a period) to be sampled.
  assign pins.raw = {switchIn, compChangeRaw, ioSupplyOk, overVoltRaw, batteryUvRaw,
                     wakeIn, intIn, mosi, sck, csN};

  smp_pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pins    (pins)
  );

  // Any wake source out of low power; edges on select and interrupt need the I/O supply.
  function automatic logic wake_source(input logic tmrHit, input logic csF, input logic intF,
                                       input logic wakeF, input logic wakeCfg,
                                       input logic comp, input logic io);
    wake_source = tmrHit | comp | (wakeF & wakeCfg) | ((csF | intF) & io);
  endfunction : wake_source

  // Filtered levels and their edges.
  assign uv       = pins.clean[`SMP_B_UV];
  assign ov       = pins.clean[`SMP_B_OV];
  assign ioOk     = pins.clean[`SMP_B_IOOK];
  assign csLvl    = pins.clean[`SMP_B_CSN];
  assign sckLvl   = pins.clean[`SMP_B_SCK];
  assign mosiLvl  = pins.clean[`SMP_B_MOSI];
  assign csFall   = q.csPrev & ~csLvl;
  assign csRise   = ~q.csPrev & csLvl;
  assign sckRise  = ~q.sckPrev & sckLvl;
  assign sckFall  = q.sckPrev & ~sckLvl;
  assign swChange = |((pins.clean[`SMP_B_SW_HI:`SMP_B_SW_LO] ^ q.swRef) & wakeEnMask);
  assign wakeReq  = wake_source((intTimerPeriod != 24'h000000) && (q.intTmr == 24'h000001),
                                csFall, q.intPrev & ~pins.clean[`SMP_B_INT],
                                q.wakePrev & ~pins.clean[`SMP_B_WAKE], wakePinWakeEn,
                                pins.clean[`SMP_B_COMP], ioOk);

  // Sequencer, serial framing and sticky flags; a flag set in the cycle of its
  // clear survives because the set is written last.
  always_comb begin
    d          = q;
    d.csPrev   = csLvl;
    d.sckPrev  = sckLvl;
    d.intPrev  = pins.clean[`SMP_B_INT];
    d.wakePrev = pins.clean[`SMP_B_WAKE];
    case (q.state)
      SMP_RESET: begin
        d.state = SMP_UV;
      end
      SMP_UV: begin
        d.frameOk = 1'b0;
        if (!uv) begin
          d.state = SMP_FUSE;
          d.cnt   = 16'h0000;
        end
      end
      SMP_FUSE: begin
        d.cnt = q.cnt + 16'h0001;
        if (uv) begin
          d.state = SMP_UV;
        end else if (q.cnt == 16'(FuseLast)) begin
          d.state = SMP_NORMAL;
        end
      end
      SMP_NORMAL: begin
        if (uv) begin
          d.state   = SMP_UV;
          d.frameOk = 1'b0;
        end else if (!ioOk) begin
          d.frameOk = 1'b0;
        end else begin
          // Framing runs only here, so every command is taken in Normal mode.
          if (csFall) begin
            d.frameOk = 1'b1;
            d.bitCnt  = 5'h00;
            d.txSh    = {q.uvSeen, q.porSeen, q.intPend, 10'h000, q.state};
            d.misoQ   = q.uvSeen;
            d.intPend = 1'b0;
          end
          if (sckRise && !csLvl && q.frameOk) begin
            d.rxSh = {q.rxSh[`SMP_WORD_BITS-2:0], mosiLvl};
            if (q.bitCnt != 5'h1F) begin
              d.bitCnt = q.bitCnt + 5'h01;
            end
          end
          if (sckFall && !csLvl && q.frameOk) begin
            d.txSh  = {q.txSh[`SMP_WORD_BITS-2:0], 1'b0};
            d.misoQ = q.txSh[`SMP_WORD_BITS-2];
          end
          if (csRise && q.frameOk) begin
            d.frameOk = 1'b0;
            if (q.bitCnt == 5'(`SMP_WORD_BITS)) begin
              d.uvSeen  = 1'b0;
              d.porSeen = 1'b0;
              if (q.rxSh == `SMP_SLEEP_CMD) begin
                d.state   = SMP_SLEEP;
                d.swRef   = pins.clean[`SMP_B_SW_HI:`SMP_B_SW_LO];
                d.pollTmr = pollPeriod;
                d.intTmr  = intTimerPeriod;
              end
            end
          end
        end
      end
      SMP_SLEEP, SMP_POLL: begin
        d.frameOk = 1'b0;
        if (q.intTmr > 24'h000001) begin
          d.intTmr = q.intTmr - 24'h000001;
        end
        if (wakeReq) begin
          d.state   = SMP_NORMAL;
          d.intPend = 1'b1;
        end else if (q.state == SMP_SLEEP) begin
          if (!uv && (wakeEnMask != '0)) begin
            if (q.pollTmr <= 24'h000001) begin
              d.state = SMP_POLL;
              d.cnt   = 16'h0000;
            end else begin
              d.pollTmr = q.pollTmr - 24'h000001;
            end
          end
        end else if (!uv) begin
          d.cnt = q.cnt + 16'h0001;
          if (q.cnt == 16'(`SMP_POLL_ACT_CYC - 1)) begin
            if (swChange) begin
              d.state   = SMP_NORMAL;
              d.intPend = 1'b1;
            end else begin
              d.state   = SMP_SLEEP;
              d.pollTmr = pollPeriod;
            end
          end
        end
      end
      default: begin
        d.state = SMP_UV;
      end
    endcase
    if (uv && (q.state != SMP_RESET)) begin
      d.uvSeen = 1'b1;
    end
  end

  // Reset places every field at its default; the por flag comes up set.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q         <= '0;
      q.state   <= SMP_RESET;
      q.porSeen <= 1'b1;
      q.csPrev  <= 1'b1;
      q.intPrev <= 1'b1;
      q.wakePrev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Pin and enable outputs decoded from the registered state.
  assign misoOut       = q.misoQ;
  assign misoOeN       = !((q.state == SMP_NORMAL) && ioOk && !csLvl && q.frameOk);
  assign intOut        = 1'b0;
  assign intOeN        = !((q.state == SMP_RESET) || (q.state == SMP_UV) ||
                           (q.state == SMP_FUSE) || q.intPend);
  assign wakeOut       = 1'b0;
  assign wakeOeN       = (q.state != SMP_NORMAL);
  assign fastOscEn     = (q.state == SMP_UV) || (q.state == SMP_FUSE) ||
                         (q.state == SMP_NORMAL);
  assign faultDetectEn = (q.state == SMP_NORMAL);
  assign currentSrcEn  = (q.state == SMP_NORMAL) || (q.state == SMP_POLL);
  assign currentLimit  = ov;
  assign muxEn         = (q.state == SMP_NORMAL);
  assign uvSeenFlag    = q.uvSeen;
  assign porSeenFlag   = q.porSeen;
  assign stateOut      = q.state;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seqLeaveUv;
    (q.state == SMP_UV) ##1 (q.state == SMP_FUSE);
  endsequence

  chk_miso_uv_off: assert property ((q.state == SMP_UV) |-> misoOeN)
    else $error("serial output driven during lockout");
  chk_uv_no_frame: assert property ((q.state == SMP_UV) |=> !q.frameOk)
    else $error("frame open during lockout");
  chk_uv_flag_set: assert property (seqLeaveUv |-> q.uvSeen)
    else $error("lockout flag missing after lockout");
  chk_reset_defaults: assert property ($past(rst) |-> (q.state == SMP_RESET) && misoOeN)
    else $error("reset did not restore defaults");
  chk_por_flag_up: assert property ($past(rst) |-> porSeenFlag ##1 (q.state == SMP_UV))
    else $error("por flag or start state wrong");
  chk_ov_limit: assert property (ov |-> currentLimit)
    else $error("overvoltage did not limit sources");
  chk_int_startup: assert property ((q.state inside {SMP_RESET, SMP_UV, SMP_FUSE}) |->
    !intOeN)
    else $error("interrupt released before ready");
  chk_fuse_length: assert property (($past(q.state) == SMP_FUSE && q.state == SMP_NORMAL)
    |-> ($past(q.cnt) == 16'(FuseLast)))
    else $error("fuse read time wrong");
  chk_wake_normal: assert property ((q.state == SMP_NORMAL) |-> !wakeOeN)
    else $error("wake line released in Normal mode");
  chk_sleep_entry: assert property (($past(q.state) == SMP_NORMAL && q.state == SMP_SLEEP)
    |-> $past(csRise) && ($past(q.rxSh) == `SMP_SLEEP_CMD))
    else $error("low power entered without command");
  chk_sleep_quiet: assert property ((q.state inside {SMP_SLEEP, SMP_POLL}) |->
    !faultDetectEn && !fastOscEn)
    else $error("fault detection active in low power");
  chk_uv_quiet: assert property ((q.state == SMP_UV) |->
    !muxEn && !currentSrcEn && fastOscEn)
    else $error("mux or sources active during lockout");
  chk_noio_quiet: assert property ((q.state == SMP_NORMAL && !ioOk) |-> misoOeN)
    else $error("serial output driven without io supply");
  chk_wake_int: assert property (($past(q.state) inside {SMP_SLEEP, SMP_POLL}) &&
    (q.state == SMP_NORMAL) |-> q.intPend)
    else $error("wake did not raise the interrupt");

  // Last active cycle of a poll that is not paused by low battery.
  sequence seqPollEnd;
    (q.state == SMP_POLL) && !uv && !wakeReq && (q.cnt == 16'(`SMP_POLL_ACT_CYC - 1));
  endsequence

  chk_poll_result: assert property (seqPollEnd |=>
    (q.state == (($past(swChange)) ? SMP_NORMAL : SMP_SLEEP)))
    else $error("poll ended in the wrong state");
  chk_poll_pause: assert property ((q.state == SMP_POLL && uv && !wakeReq) |=>
    (q.state == SMP_POLL) && $stable(q.cnt))
    else $error("polling advanced at low battery");
  chk_poll_idle: assert property ((q.state == SMP_SLEEP && wakeEnMask == '0) |=>
    $stable(q.pollTmr) && (q.state != SMP_POLL))
    else $error("polling timer ran with no wake enables");

endmodule : smp_power_fsm

//--- src/smp_sync_if.sv
`timescale 1ns/10ps
`include "smp_defs.svh"

// Bundle of raw pins and their filtered copies on ref_clk.
interface smp_sync_if;
  logic [`SMP_SYNC_W-1:0] raw;
  logic [`SMP_SYNC_W-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface : smp_sync_if

//--- test/smp_host_model.sv
`timescale 1ns/10ps

module smp_host_model (
  input  wire logic ref_clk, // System clock that paces the serial clock.
  output logic      csN,     // Chip select to the device, active low.
  output logic      sck,     // Serial clock, parked low between words.
  output logic      mosi,    // Serial data to the device.
  input  wire logic miso     // Resolved serial data line from the device.
);
  // Idle levels before the first word.
  initial begin
    csN  = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end

  // One whole word, MSB first, at 400 ns per bit; read data is taken just before each
  // falling sck, since the device only moves its output some cycles after that edge.
  // Select stays high for 600 ns before the task returns, so words may follow at once.
  task automatic xfer(input logic [15:0] word, output logic [15:0] resp);
    @(posedge ref_clk);
    csN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      mosi <= word[i];
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      resp[i] = miso;
      @(posedge ref_clk);
      sck <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    csN  <= 1'b1;
    mosi <= ~mosi; // Parked data must not look like the last bit sent.
    repeat (12) @(posedge ref_clk);
  endtask : xfer

  // The word that wakes the device by select carries no valid answer, so it is dropped.
  task automatic wake_by_select;
    logic [15:0] dropped;
    xfer(16'h0000, dropped);
  endtask : wake_by_select
endmodule : smp_host_model

//--- test/switch_monitor_power_state_machine_tb_top.sv
`timescale 1ns/10ps
`include "smp_defs.svh"

module switch_monitor_power_state_machine_tb_top;
  import smp_pkg::*;

  // One table row: supply inputs, cycles to wait, expected outputs and the bits that matter.
  typedef struct packed {
    logic        uv;
    logic        ov;
    logic        io;
    logic [11:0] waitCyc;
    logic [11:0] exp;
    logic [11:0] mask;
  } smp_row_t;

  logic                     ref_clk        = 1'b0;
  logic                     rst            = 1'b1;
  logic                     batteryUvRaw   = 1'b1;
  logic                     overVoltRaw    = 1'b0;
  logic                     ioSupplyOk     = 1'b1;
  logic                     compChangeRaw  = 1'b0;
  logic [`SMP_CHANNELS-1:0] switchIn       = '0;
  logic [`SMP_CHANNELS-1:0] wakeEnMask     = '0;
  logic                     wakePinWakeEn  = 1'b0;
  logic [23:0]              pollPeriod     = 24'h000064;
  logic [23:0]              intTimerPeriod = 24'h000000;
  logic                     intExt         = 1'b1;
  logic                     wakeExt        = 1'b1;
  logic                     csN, sck, mosi, misoOut, misoOeN, intOut, intOeN, wakeOut, wakeOeN;
  logic                     fastOscEn, faultDetectEn, currentSrcEn, currentLimit, muxEn;
  logic                     uvSeenFlag, porSeenFlag;
  smp_state_t               stateOut;
  logic [15:0]              rsp;
  int                       miscompares    = 0;
  int                       total_checks   = 0;
  smp_row_t                 rows [7]       = '{
    {1'b0, 1'b0, 1'b1, 12'd20, 12'h6F4, 12'hFFF},
    {1'b0, 1'b1, 1'b1, 12'd20, 12'h6FC, 12'hFFF},
    {1'b0, 1'b0, 1'b0, 12'd20, 12'h6F4, 12'hFFF},
    {1'b1, 1'b0, 1'b1, 12'd20, 12'h386, 12'hFBE},
    {1'b0, 1'b0, 1'b1, 12'd30, 12'h400, 12'hE00},
    {1'b0, 1'b0, 1'b1, 12'd940, 12'h400, 12'hE00},
    {1'b0, 1'b0, 1'b1, 12'd60, 12'h602, 12'hF02}
  };

  // The clock toggles every half period of the 50 ns cycle.
  always #25 ref_clk = ~ref_clk;

  // Wire levels of the shared lines; interrupt and wake lines are pulled up, and a
  // released data line shows the inverse so that a stale bit cannot pass.
  wire        misoLine = misoOeN ? ~misoOut : misoOut;
  wire        intLine  = intOeN ? intExt : intOut;
  wire        wakeLine = wakeOeN ? wakeExt : wakeOut;
  wire [11:0] obs      = {stateOut, wakeOeN, fastOscEn, faultDetectEn, currentSrcEn, muxEn,
                          currentLimit, misoOeN, uvSeenFlag, porSeenFlag};

  smp_power_fsm u_dut (
    .ref_clk(ref_clk), .rst(rst), .batteryUvRaw(batteryUvRaw), .overVoltRaw(overVoltRaw),
    .ioSupplyOk(ioSupplyOk), .compChangeRaw(compChangeRaw), .switchIn(switchIn),
    .wakeEnMask(wakeEnMask), .wakePinWakeEn(wakePinWakeEn), .pollPeriod(pollPeriod),
    .intTimerPeriod(intTimerPeriod), .csN(csN), .sck(sck), .mosi(mosi), .misoOut(misoOut),
    .misoOeN(misoOeN), .intIn(intLine), .intOut(intOut), .intOeN(intOeN), .wakeIn(wakeLine),
    .wakeOut(wakeOut), .wakeOeN(wakeOeN), .fastOscEn(fastOscEn), .faultDetectEn(faultDetectEn),
    .currentSrcEn(currentSrcEn), .currentLimit(currentLimit), .muxEn(muxEn),
    .uvSeenFlag(uvSeenFlag), .porSeenFlag(porSeenFlag), .stateOut(stateOut)
  );

  smp_host_model u_host (.ref_clk(ref_clk), .csN(csN), .sck(sck), .mosi(mosi), .miso(misoLine));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Waits a bounded time for a state, then compares it.
  task automatic wait_state(input smp_state_t s, input int n);
    for (int i = 0; i < n && stateOut !== s; i++) @(posedge ref_clk);
    check("state", 16'(stateOut), 16'(s));
  endtask : wait_state

  task automatic comp_pulse;
    compChangeRaw <= 1'b1;
    repeat (10) @(posedge ref_clk);
    compChangeRaw <= 1'b0;
  endtask : comp_pulse

  // Reset with the battery in lockout, then climb to Normal mode and read the flags twice.
  task automatic boot;
    rst          <= 1'b1;
    batteryUvRaw <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("rst", 16'({stateOut, misoOeN, intOeN, wakeOeN, porSeenFlag}), 16'({SMP_RESET, 4'hB}));
    rst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    check("uv", 16'({stateOut, misoOeN, intOeN}), 16'({SMP_UV, 2'b10}));
    batteryUvRaw <= 1'b0;
    wait_state(SMP_FUSE, 20);
    check("boot", 16'({intOeN, misoOeN}), 16'h0001);
    wait_state(SMP_NORMAL, 1100);
    u_host.xfer(16'h0000, rsp);
    check("rsp", rsp & 16'hDFFF, 16'hC003);
    u_host.xfer(16'h0000, rsp);
    check("rsp", rsp & 16'hDFFF, 16'h0003);
  endtask : boot

  task automatic test_done;
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Main sequence: table of supply cases, then the awkward cases by hand.
  initial begin
    boot();
    foreach (rows[k]) begin
      batteryUvRaw <= rows[k].uv;
      overVoltRaw  <= rows[k].ov;
      ioSupplyOk   <= rows[k].io;
      repeat (rows[k].waitCyc) @(posedge ref_clk);
      check("row", 16'(obs & rows[k].mask), 16'(rows[k].exp));
    end
    // Lockout in mid-word drops the low-power command that was being sent.
    fork
      u_host.xfer(`SMP_SLEEP_CMD, rsp);
      begin
        repeat (60) @(posedge ref_clk);
        batteryUvRaw <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check("lock", 16'({stateOut, misoOeN}), 16'({SMP_UV, 1'b1}));
      end
    join
    batteryUvRaw <= 1'b0;
    wait_state(SMP_NORMAL, 1100);
    ioSupplyOk <= 1'b0;
    u_host.xfer(`SMP_SLEEP_CMD, rsp);
    check("noio", 16'({stateOut, misoOeN}), 16'({SMP_NORMAL, 1'b1}));
    ioSupplyOk <= 1'b1;
    // Each wake source in turn: timer, comparator, select, wake line, interrupt line.
    for (int src = 0; src < 5; src++) begin
      intTimerPeriod <= (src == 0) ? 24'h000040 : 24'h000000;
      wakePinWakeEn  <= (src == 3);
      u_host.xfer(`SMP_SLEEP_CMD, rsp);
      check("sleep", 16'({stateOut, fastOscEn, faultDetectEn, wakeOeN}), 16'({SMP_SLEEP, 3'b001}));
      case (src)
        1: comp_pulse();
        2: u_host.wake_by_select();
        3: wakeExt <= 1'b0;
        4: intExt <= 1'b0;
        default: ;
      endcase
      wait_state(SMP_NORMAL, 300);
      if (src != 2) check("int", 16'(intOeN), 16'h0000);
      wakeExt <= 1'b1;
      intExt  <= 1'b1;
    end
    // Polling on one live channel: first poll sees no change, second one does.
    wakeEnMask <= 22'h000001;
    u_host.xfer(`SMP_SLEEP_CMD, rsp);
    wait_state(SMP_POLL, 150);
    wait_state(SMP_SLEEP, 250);
    switchIn <= 22'h000001;
    wait_state(SMP_POLL, 150);
    wait_state(SMP_NORMAL, 250);
    check("int", 16'(intOeN), 16'h0000);
    // Low battery in low-power mode and in a poll pauses polling without waking.
    u_host.xfer(`SMP_SLEEP_CMD, rsp);
    batteryUvRaw <= 1'b1;
    repeat (300) @(posedge ref_clk);
    check("pause", 16'(stateOut), 16'(SMP_SLEEP));
    batteryUvRaw <= 1'b0;
    wait_state(SMP_POLL, 150);
    batteryUvRaw <= 1'b1;
    repeat (300) @(posedge ref_clk);
    check("pause", 16'(stateOut), 16'(SMP_POLL));
    batteryUvRaw <= 1'b0;
    comp_pulse();
    wait_state(SMP_NORMAL, 300);
    // With no channel enabled, neither polling nor a switch change may wake the device.
    wakeEnMask <= '0;
    u_host.xfer(`SMP_SLEEP_CMD, rsp);
    switchIn <= 22'h000000;
    repeat (150) @(posedge ref_clk);
    check("mask", 16'(stateOut), 16'(SMP_SLEEP));
    repeat (250) @(posedge ref_clk);
    check("mask", 16'(stateOut), 16'(SMP_SLEEP));
    boot();
    test_done();
  end

  // Guard against a hang; the whole run needs well under 20000 cycles.
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
endmodule : switch_monitor_power_state_machine_tb_top
